// ===== core/imt_irq_ctrl.sv
// Interrupt mask, event status flags and transmit status for the controller.
//
// How it works
// - Underrun flag never sets while loopback is asserted; an earlier set value holds.
// - Underrun flag sets when FIFO empties before bus is won.
// - Length differing from fragment sum sets mismatch and aborts transmit.
// - Too many collisions during transmit also set the mismatch flag.
// - Sent-ok flag sets only when no transmit error occurred.
// - Mask register answers at register address four.
// - A one in a mask bit enables that source; zero blocks it.
// - Hardware reset clears the whole mask.
// - Mask bit 14 enables the bus retry interrupt.
// - Mask bit 13 enables the heartbeat loss interrupt.
// - Mask bit 12 enables the table load done interrupt.
// - Mask bit 11 enables the descriptor flag interrupt.
// - Mask bit 10 enables the received packet interrupt.
// - Transmit ok mask bit enables interrupt per successful transmit completion.
// - Transmit error mask bit enables interrupt per failed packet.
// - Mask bits 7 to 0 enable timer, receive and tally events.
// - Interrupt output rises one cycle after a set flag is enabled and falls one cycle after none is.
// - Status flags clear on writing one; zero leaves them.
`include "imt_cfg.svh"
module imt_irq_ctrl (
    input  wire logic            i_core_clk,
    input  wire logic            i_rstn,
    input  wire imt_pkg::imt_addr_t i_register_select,
    input  wire logic            i_reg_wr,
    input  wire logic            i_reg_rd,
    input  wire imt_pkg::imt_word_t i_reg_wdata,
    output imt_pkg::imt_word_t   o_reg_rdata,
    input  wire logic            i_bus_retry,
    input  wire logic            i_heartbeat_loss,
    input  wire logic            i_table_load_done,
    input  wire logic            i_rx_packet,
    input  wire logic [7:0]      i_low_events,
    input  wire logic            i_tx_start,
    input  wire logic            i_tx_end,
    input  wire logic            i_descriptor_flag_irq,
    input  wire logic            i_loopback,
    input  wire logic            i_fifo_empty,
    input  wire logic            i_bus_granted,
    input  wire logic [15:0]     i_tx_descriptor_total_length,
    input  wire logic [15:0]     i_fragment_sum,
    input  wire logic            i_fragments_done,
    input  wire logic            i_too_many_collisions,
    input  wire logic            i_excess_deferral,
    output logic                 o_tx_abort,
    output logic                 o_irq
);
    import imt_pkg::*;

    imt_word_t interrupt_enable_mask_r;
    imt_word_t event_status_flags_r;
    imt_word_t event_set;
    imt_word_t status_clear;
    logic [2:0] tx_status;
    logic       tx_ok_pulse;
    logic       tx_err_pulse;
    logic       tx_busy;
    logic       tx_descriptor_flag_irq_r;

    imt_tx_status u_tx_status (
        .i_core_clk           (i_core_clk),
        .i_rstn               (i_rstn),
        .i_tx_start           (i_tx_start),
        .i_tx_end             (i_tx_end),
        .i_loopback           (i_loopback),
        .i_fifo_empty         (i_fifo_empty),
        .i_bus_granted        (i_bus_granted),
        .i_total_length       (i_tx_descriptor_total_length),
        .i_fragment_sum       (i_fragment_sum),
        .i_fragments_done     (i_fragments_done),
        .i_too_many_collisions(i_too_many_collisions),
        .i_excess_deferral    (i_excess_deferral),
        .o_abort              (o_tx_abort),
        .o_busy               (tx_busy),
        .o_tx_status          (tx_status),
        .o_tx_ok_pulse        (tx_ok_pulse),
        .o_tx_err_pulse       (tx_err_pulse)
    );

    // The descriptor flag is latched at start so it fires once per packet.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_descriptor_flag_irq_r <= 1'b0;
        end else if (i_tx_start && !tx_busy) begin
            tx_descriptor_flag_irq_r <= i_descriptor_flag_irq;
        end else if (tx_ok_pulse || tx_err_pulse) begin
            tx_descriptor_flag_irq_r <= 1'b0;
        end
    end

    always_comb begin
        event_set                     = '0;
        event_set[`IMT_BIT_BR]        = i_bus_retry;
        event_set[`IMT_BIT_HBL]       = i_heartbeat_loss;
        event_set[`IMT_BIT_LCD]       = i_table_load_done;
        event_set[`IMT_BIT_DESCRIPTOR_FLAG_IRQ]      = tx_descriptor_flag_irq_r
                                        && (tx_ok_pulse || tx_err_pulse);
        event_set[`IMT_BIT_PKTRX]     = i_rx_packet;
        event_set[`IMT_BIT_TXOK]      = tx_ok_pulse;
        event_set[`IMT_BIT_TXERR]     = tx_err_pulse;
        event_set[`IMT_LOW_EVENTS-1:0] = i_low_events;
    end

    assign status_clear = (i_reg_wr && i_register_select == `IMT_RA_STATUS)
                          ? i_reg_wdata : '0;

    // Mask register: the top bit is held at zero whatever software writes.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            interrupt_enable_mask_r <= `IMT_MASK_RST;
        end else if (i_reg_wr && i_register_select == `IMT_RA_MASK) begin
            interrupt_enable_mask_r <= i_reg_wdata
                & ~(16'h0001 << `IMT_TOPBIT);
        end
    end

    // A new event beats a clear in the same cycle; mask writes never touch it.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            event_status_flags_r <= `IMT_STATUS_RST;
        end else begin
            event_status_flags_r <= ((event_status_flags_r & ~status_clear)
                | event_set) & ~(16'h0001 << `IMT_TOPBIT);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(event_status_flags_r
                       & interrupt_enable_mask_r);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= '0;
        end else if (i_reg_rd) begin
            unique case (i_register_select)
                `IMT_RA_MASK:   o_reg_rdata <= interrupt_enable_mask_r;
                `IMT_RA_STATUS: o_reg_rdata <= event_status_flags_r;
                `IMT_RA_TXSTAT: o_reg_rdata <= {13'h0000, tx_status};
                default:        o_reg_rdata <= '0;
            endcase
        end
    end

    AST_MASK_WRITE: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        (i_reg_wr && i_register_select == `IMT_RA_MASK)
        |=> interrupt_enable_mask_r[14:0] == $past(i_reg_wdata[14:0]))
        else $error("Mask write not stored.");
    AST_MASK_TOP_ZERO: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        !interrupt_enable_mask_r[`IMT_TOPBIT])
        else $error("Mask top bit set.");
    AST_IRQ_GATED: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        o_irq == |$past(event_status_flags_r & interrupt_enable_mask_r))
        else $error("Interrupt output disagrees with flags and mask.");
    AST_MASKED_QUIET: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        (interrupt_enable_mask_r == '0) [*2] |-> !o_irq)
        else $error("Interrupt with all sources masked.");
    AST_CLEAR_ON_ONE: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        (status_clear[0] && !event_set[0]) |=> !event_status_flags_r[0])
        else $error("Flag not cleared by one.");
    AST_SET_WINS: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        event_set[`IMT_BIT_BR] |=> event_status_flags_r[`IMT_BIT_BR])
        else $error("Event lost.");
    AST_MASK_KEEPS_FLAGS: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        (i_reg_wr && i_register_select == `IMT_RA_MASK)
        |=> (event_status_flags_r & ~$past(event_status_flags_r)) ==
            ($past(event_set) & ~$past(event_status_flags_r)
             & ~(16'h0001 << `IMT_TOPBIT)))
        else $error("Mask write changed flags.");
    AST_TXOK_FLAG: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        tx_ok_pulse |=> event_status_flags_r[`IMT_BIT_TXOK])
        else $error("Transmit ok not flagged.");
    COV_IRQ: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_irq);
    COV_LATE_ENABLE: cover property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        (|event_status_flags_r && interrupt_enable_mask_r == '0)
        ##1 (interrupt_enable_mask_r != '0) ##1 o_irq);
endmodule : imt_irq_ctrl

// ===== core/imt_cfg.svh
// Register addresses, field positions and reset values for the interrupt block.
`ifndef IMT_CFG_SVH
`define IMT_CFG_SVH
`define IMT_RA_W          6
`define IMT_RA_MASK       6'h04
`define IMT_RA_STATUS     6'h05
`define IMT_RA_TXSTAT     6'h06
`define IMT_REG_W         16
`define IMT_MASK_RST      16'h0000
`define IMT_STATUS_RST    16'h0000
`define IMT_TXSTAT_RST    3'h0
`define IMT_TOPBIT        15
`define IMT_BIT_BR        14
`define IMT_BIT_HBL       13
`define IMT_BIT_LCD       12
`define IMT_BIT_DESCRIPTOR_FLAG_IRQ      11
`define IMT_BIT_PKTRX     10
`define IMT_BIT_TXOK      9
`define IMT_BIT_TXERR     8
`define IMT_TS_OK         0
`define IMT_TS_BCM        1
`define IMT_TS_FU         2
`define IMT_LOW_EVENTS    8
`endif

// ===== core/imt_pkg.sv
// Shared types for the interrupt mask and transmit status block.
package imt_pkg;
    typedef logic [15:0] imt_word_t;
    typedef logic [5:0]  imt_addr_t;
    typedef enum logic [2:0] {
        IMT_TX_IDLE = 3'b001,
        IMT_TX_BUSY = 3'b010,
        IMT_TX_DONE = 3'b100
    } imt_tx_state_e;
endpackage : imt_pkg

// ===== core/imt_tx_status.sv
// Transmit completion status flags for one packet.
`include "imt_cfg.svh"
module imt_tx_status (
    input  wire logic            i_core_clk,
    input  wire logic            i_rstn,
    input  wire logic            i_tx_start,
    input  wire logic            i_tx_end,
    input  wire logic            i_loopback,
    input  wire logic            i_fifo_empty,
    input  wire logic            i_bus_granted,
    input  wire logic [15:0]     i_total_length,
    input  wire logic [15:0]     i_fragment_sum,
    input  wire logic            i_fragments_done,
    input  wire logic            i_too_many_collisions,
    input  wire logic            i_excess_deferral,
    output logic                 o_abort,
    output logic                 o_busy,
    output logic [2:0]           o_tx_status,
    output logic                 o_tx_ok_pulse,
    output logic                 o_tx_err_pulse
);
    import imt_pkg::*;

    imt_tx_state_e state_r;
    logic          underrun_now;
    logic          mismatch_now;
    logic          err_r;

    // Loopback never reports underrun because the FIFO is not drained by a bus.
    assign underrun_now = (state_r == IMT_TX_BUSY) && i_fifo_empty
                          && !i_bus_granted && !i_loopback;
    assign mismatch_now = (state_r == IMT_TX_BUSY) && ((i_fragments_done
                          && (i_total_length != i_fragment_sum))
                          || i_too_many_collisions);
    assign o_abort = mismatch_now;
    assign o_busy  = (state_r == IMT_TX_BUSY);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= IMT_TX_IDLE;
        end else begin
            unique case (state_r)
                IMT_TX_IDLE: begin
                    if (i_tx_start) begin
                        state_r <= IMT_TX_BUSY;
                    end
                end
                IMT_TX_BUSY: begin
                    if (i_tx_end || mismatch_now) begin
                        state_r <= IMT_TX_DONE;
                    end
                end
                IMT_TX_DONE: begin
                    state_r <= IMT_TX_IDLE;
                end
                default: begin
                    state_r <= IMT_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_status <= `IMT_TXSTAT_RST;
            err_r       <= 1'b0;
        end else if (state_r == IMT_TX_IDLE && i_tx_start) begin
            o_tx_status <= `IMT_TXSTAT_RST;
            err_r       <= 1'b0;
        end else if (state_r == IMT_TX_BUSY) begin
            if (underrun_now) begin
                o_tx_status[`IMT_TS_FU] <= 1'b1;
            end
            if (mismatch_now) begin
                o_tx_status[`IMT_TS_BCM] <= 1'b1;
            end
            if (i_excess_deferral) begin
                err_r <= 1'b1;
            end
            if ((i_tx_end || mismatch_now) && !mismatch_now && !underrun_now
                && !o_tx_status[`IMT_TS_FU] && !err_r
                && !i_excess_deferral) begin
                o_tx_status[`IMT_TS_OK] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_ok_pulse  <= 1'b0;
            o_tx_err_pulse <= 1'b0;
        end else begin
            o_tx_ok_pulse  <= (state_r == IMT_TX_DONE)
                              && o_tx_status[`IMT_TS_OK];
            o_tx_err_pulse <= (state_r == IMT_TX_DONE)
                              && !o_tx_status[`IMT_TS_OK];
        end
    end

    AST_LOOPBACK_NO_FU: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        (state_r == IMT_TX_BUSY && i_loopback && $past(i_loopback)
         && $past(state_r) == IMT_TX_BUSY && !$past(o_tx_status[`IMT_TS_FU]))
        |-> !o_tx_status[`IMT_TS_FU])
        else $error("Underrun flagged in loopback.");
    AST_UNDERRUN_SETS: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        underrun_now |=> o_tx_status[`IMT_TS_FU])
        else $error("Underrun not flagged.");
    AST_MISMATCH_ABORTS: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        mismatch_now |=> o_tx_status[`IMT_TS_BCM]
                         && state_r == IMT_TX_DONE)
        else $error("Mismatch did not abort.");
    AST_COLLISIONS_SET_BCM: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        (state_r == IMT_TX_BUSY && i_too_many_collisions)
        |=> o_tx_status[`IMT_TS_BCM])
        else $error("Collisions did not set mismatch.");
    AST_OK_EXCLUSIVE: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        o_tx_status[`IMT_TS_OK] |-> !o_tx_status[`IMT_TS_BCM]
                                    && !o_tx_status[`IMT_TS_FU])
        else $error("OK set with an error.");
    COV_TX_OK: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_tx_ok_pulse);
    COV_TX_ABORT: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_abort);
endmodule : imt_tx_status

// ===== test/imt_host_model.sv
// Host software model that reaches the interrupt block's registers.
`include "imt_cfg.svh"
module imt_host_model (
    input  wire logic               i_core_clk,
    input  wire imt_pkg::imt_word_t i_reg_rdata,
    output imt_pkg::imt_addr_t      o_register_select,
    output logic                    o_reg_wr,
    output logic                    o_reg_rd,
    output imt_pkg::imt_word_t      o_reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import imt_pkg::*;

    initial begin
        o_register_select = 6'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 16'h0000;
    end

    task automatic reg_write(input imt_addr_t a, input imt_word_t d);
        @(negedge i_core_clk);
        o_register_select = a;
        // Software keeps the top mask bit clear on every mask write.
        o_reg_wdata = (a == `IMT_RA_MASK) ? {1'b0, d[14:0]} : d;
        o_reg_wr = 1'b1;
        @(negedge i_core_clk);
        o_reg_wr = 1'b0;
        // Released data is scrambled so a stale value cannot be reused.
        o_reg_wdata = ~o_reg_wdata;
    endtask : reg_write

    task automatic reg_read(input imt_addr_t a, output imt_word_t d);
        @(negedge i_core_clk);
        o_register_select = a;
        o_reg_rd = 1'b1;
        @(negedge i_core_clk);
        o_reg_rd = 1'b0;
        d = i_reg_rdata;
    endtask : reg_read
endmodule : imt_host_model

// ===== test/irq_mask_and_tx_status_tb.sv
// Self-checking bench for the interrupt mask and transmit status block.
`include "imt_cfg.svh"
module irq_mask_and_tx_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import imt_pkg::*;

    typedef struct {imt_word_t mask; imt_word_t ev; logic irq;} imt_row_s;

    logic      i_core_clk;
    logic      i_rstn = 1'b0;
    imt_addr_t sel;
    logic      wr;
    logic      rd;
    imt_word_t wdata;
    imt_word_t rdata;
    imt_word_t ev_r = 16'h0000;
    logic      tx_start = 1'b0;
    logic      tx_end = 1'b0;
    logic      desc = 1'b0;
    logic      lpbk = 1'b0;
    logic      fempty = 1'b0;
    logic      bgrant = 1'b1;
    logic      fdone = 1'b0;
    logic      col = 1'b0;
    logic      dfr = 1'b0;
    imt_word_t frag = 16'h0040;
    imt_word_t tlen = 16'h0040;
    logic      o_tx_abort;
    logic      o_irq;
    int        failures = 0;
    int        n_checks = 0;
    int        cyc = 0;
    imt_word_t seen;

    imt_row_s rows [8] = '{
        '{16'h4000, 16'h4000, 1'b1},
        '{16'h2000, 16'h2000, 1'b1},
        '{16'h1000, 16'h1000, 1'b1},
        '{16'h0400, 16'h0400, 1'b1},
        '{16'h0080, 16'h0080, 1'b1},
        '{16'h0001, 16'h0001, 1'b1},
        '{16'h3fff, 16'h4000, 1'b0},
        '{16'h0000, 16'h00ff, 1'b0}
    };

    imt_host_model host (
        .i_core_clk        (i_core_clk),
        .i_reg_rdata       (rdata),
        .o_register_select (sel),
        .o_reg_wr          (wr),
        .o_reg_rd          (rd),
        .o_reg_wdata       (wdata)
    );

    imt_irq_ctrl DUT (
        .i_core_clk                   (i_core_clk),
        .i_rstn                       (i_rstn),
        .i_register_select            (sel),
        .i_reg_wr                     (wr),
        .i_reg_rd                     (rd),
        .i_reg_wdata                  (wdata),
        .o_reg_rdata                  (rdata),
        .i_bus_retry                  (ev_r[14]),
        .i_heartbeat_loss             (ev_r[13]),
        .i_table_load_done            (ev_r[12]),
        .i_rx_packet                  (ev_r[10]),
        .i_low_events                 (ev_r[7:0]),
        .i_tx_start                   (tx_start),
        .i_tx_end                     (tx_end),
        .i_descriptor_flag_irq        (desc),
        .i_loopback                   (lpbk),
        .i_fifo_empty                 (fempty),
        .i_bus_granted                (bgrant),
        .i_tx_descriptor_total_length (tlen),
        .i_fragment_sum               (frag),
        .i_fragments_done             (fdone),
        .i_too_many_collisions        (col),
        .i_excess_deferral            (dfr),
        .o_tx_abort                   (o_tx_abort),
        .o_irq                        (o_irq)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // A hang costs at most a few thousand cycles before the verdict.
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input imt_word_t e,
                       input imt_word_t g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic pulse(input imt_word_t ev);
        @(negedge i_core_clk);
        ev_r = ev;
        @(negedge i_core_clk);
        ev_r = 16'h0000;
    endtask : pulse

    // Bits of c: descriptor flag, loopback, fifo empty, length mismatch,
    // collisions, deferral.
    task automatic tx_run(input logic [5:0] c, input logic [2:0] st,
                          input imt_word_t fl);
        @(negedge i_core_clk);
        tx_start = 1'b1;
        desc = c[5];
        frag = c[2] ? 16'h003f : 16'h0040;
        if (tlen != 16'h0040) begin
            c[2] = 1'b1;
        end
        @(negedge i_core_clk);
        tx_start = 1'b0;
        {lpbk, fempty, col, dfr, fdone} = {c[4], c[3], c[1], c[0], 1'b1};
        bgrant = ~c[3];
        #1;
        chk("abort", {15'h0, c[2] | c[1]}, {15'h0, o_tx_abort});
        @(negedge i_core_clk);
        {lpbk, fempty, col, dfr, fdone, desc} = 6'h00;
        bgrant = 1'b1;
        tx_end = ~(c[2] | c[1]);
        @(negedge i_core_clk);
        tx_end = 1'b0;
        repeat (6) @(negedge i_core_clk);
        host.reg_read(`IMT_RA_TXSTAT, seen);
        chk("tx status", {13'h0, st}, seen);
        chk("irq", 16'h0001, {15'h0, o_irq});
        host.reg_read(`IMT_RA_STATUS, seen);
        chk("status", fl, seen);
        host.reg_write(`IMT_RA_STATUS, 16'h7fff);
        $display("test tx %b done", c);
    endtask : tx_run

    initial begin
        repeat (6) @(negedge i_core_clk);
        i_rstn = 1'b1;
        host.reg_read(`IMT_RA_MASK, seen);
        chk("mask", 16'h0000, seen);
        chk("irq", 16'h0000, {15'h0, o_irq});
        $display("test reset done");
        foreach (rows[i]) begin
            host.reg_write(`IMT_RA_MASK, rows[i].mask);
            host.reg_read(`IMT_RA_MASK, seen);
            chk("mask", rows[i].mask, seen);
            pulse(rows[i].ev);
            repeat (2) @(negedge i_core_clk);
            chk("irq", {15'h0, rows[i].irq}, {15'h0, o_irq});
            host.reg_read(`IMT_RA_STATUS, seen);
            chk("status", rows[i].ev, seen);
            host.reg_write(`IMT_RA_STATUS, rows[i].ev);
            host.reg_read(`IMT_RA_STATUS, seen);
            chk("status", 16'h0000, seen);
            chk("irq", 16'h0000, {15'h0, o_irq});
            $display("test row %0d done", i);
        end
        // A source enabled after its event still raises the output.
        host.reg_write(`IMT_RA_MASK, 16'h0000);
        pulse(16'h0400);
        repeat (2) @(negedge i_core_clk);
        chk("irq", 16'h0000, {15'h0, o_irq});
        host.reg_write(`IMT_RA_MASK, 16'h0400);
        @(negedge i_core_clk);
        chk("irq", 16'h0001, {15'h0, o_irq});
        host.reg_write(`IMT_RA_STATUS, 16'h0000);
        host.reg_read(`IMT_RA_STATUS, seen);
        chk("status", 16'h0400, seen);
        host.reg_write(`IMT_RA_STATUS, 16'h0400);
        host.reg_write(6'h3f, 16'hffff);
        host.reg_read(6'h3f, seen);
        chk("unmapped", 16'h0000, seen);
        host.reg_read(`IMT_RA_MASK, seen);
        chk("mask", 16'h0400, seen);
        $display("test late enable done");
        host.reg_write(`IMT_RA_MASK, 16'h0b00);
        tx_run(6'b100000, 3'b001, 16'h0a00);
        tx_run(6'b000100, 3'b010, 16'h0100);
        tx_run(6'b000010, 3'b010, 16'h0100);
        tx_run(6'b001000, 3'b100, 16'h0100);
        tx_run(6'b011000, 3'b001, 16'h0200);
        tx_run(6'b000001, 3'b000, 16'h0100);
        // Same mismatch with the length side moved instead of the sum.
        @(negedge i_core_clk);
        tlen = 16'h0041;
        tx_run(6'b000000, 3'b010, 16'h0100);
        tlen = 16'h0040;
        host.reg_write(`IMT_RA_MASK, 16'h00ff);
        pulse(16'h0001);
        repeat (2) @(negedge i_core_clk);
        i_rstn = 1'b0;
        #1;
        chk("irq", 16'h0000, {15'h0, o_irq});
        repeat (2) @(negedge i_core_clk);
        i_rstn = 1'b1;
        host.reg_read(`IMT_RA_MASK, seen);
        chk("mask", 16'h0000, seen);
        host.reg_read(`IMT_RA_STATUS, seen);
        chk("status", 16'h0000, seen);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : irq_mask_and_tx_status_tb
